/* File: fsq_pkg.sv */
/*
  fsq_pkg: register map, field positions, reset values and codes
  for the flash sequencer status and command register slice.
  assumes: a 32-bit avalon-mm slave with byte addresses.
*/
`default_nettype none
package fsq_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_IRQ_EN    = 5'h00; // transfer_error_irq_enable
  localparam logic [4:0] OFS_CMD_HIST  = 5'h04; // command_history
  localparam logic [4:0] OFS_PE_SRC    = 5'h08; // program_erase_error_source
  localparam logic [4:0] OFS_BC_DIR    = 5'h0c; // blank_check_direction_ctrl
  localparam logic [4:0] OFS_XFER_STAT = 5'h10; // transfer_error_status
  localparam logic [4:0] OFS_EVT_STAT  = 5'h14; // sticky event status, w1c
  localparam logic [4:0] OFS_EVT_MASK  = 5'h18; // event mask
  localparam logic [4:0] OFS_SETUP     = 5'h1c; // setup_init_reg

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_SINGLE = 0; // single correct / its enable
  localparam int BIT_DOUBLE = 1; // double detect / its enable
  localparam int BIT_SCAN   = 0; // scan_direction_bit
  localparam int BIT_SETUP  = 0; // setup_init_bit
  localparam int EVT_W      = 4;
  localparam int EVT_DOUBLE = 0;
  localparam int EVT_SINGLE = 1;
  localparam int EVT_CMD    = 2;
  localparam int EVT_PEERR  = 3;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  IRQ_EN_RST  = 2'h0;
  localparam logic [15:0] CMD_RST     = 16'h0000;
  localparam logic [7:0]  PE_SRC_RST  = 8'h00;
  localparam logic [7:0]  PE_NONE     = 8'h00;
  localparam logic [7:0]  PE_LOCK_WR  = 8'h01;
  localparam logic [7:0]  PE_LOCK_ER  = 8'h02;
  localparam logic [7:0]  PE_ERASE    = 8'h12;
  localparam logic [7:0]  CMD_FINAL   = 8'hd0; // final step of two-step commands
  localparam logic [7:0]  PFX_ERASE   = 8'h20;
  localparam logic [7:0]  PFX_BLANK   = 8'h71;
  localparam logic [7:0]  PFX_LOCKPRG = 8'h77;

  // accepted command report
  typedef struct packed {
    logic       two_step; // final step of a two-step command
    logic [7:0] prefix;   // first step code of a two-step command
    logic [7:0] code;     // accepted code
  } fsq_cmd_t;

  // programming/erasure completion report
  typedef struct packed {
    logic       ready;     // sequencer_ready_flag
    logic       erase_err; // erase_error_flag
    logic       prog_err;  // program_error_flag
    logic [7:0] source;    // error source code
  } fsq_pe_t;

endpackage
`default_nettype wire

/* File: fsq_regs.sv */
/*
  fsq_regs: avalon-mm register slice of the flash sequencer:
  transfer error flags and their irq enables, command history,
  programming/erasure error source, blank check direction.
  assumes: one clock, inputs synchronous to clk_i, one-cycle pulses
  for transfer error events and command acceptance.
*/
`timescale 1ns/1ps
`default_nettype none
module fsq_regs
(
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic [4:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,
  input  wire logic             double_err_i,
  input  wire logic             single_corr_i,
  input  wire logic             cmd_accept_i,
  input  wire fsq_pkg::fsq_cmd_t cmd_i,
  input  wire fsq_pkg::fsq_pe_t  pe_i,
  output logic                  transfer_error_irq_o,
  output logic                  scan_direction_o,
  output logic                  irq_o
);

  // ----------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // two flops release the asynchronous reset
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int EVT_W = fsq_pkg::EVT_W;

  logic [1:0]          irq_en;
  logic [1:0]          xfer_stat;
  logic [15:0]         cmd_hist;
  logic [7:0]          pe_src;
  logic                scan_dir;
  logic [EVT_W-1:0]    evt_stat;
  logic [EVT_W-1:0]    evt_mask;
  logic                next_waitreq;
  logic [31:0]         next_rdata;
  logic [1:0]          next_irq_en;
  logic [1:0]          next_xfer_stat;
  logic [15:0]         next_cmd_hist;
  logic [7:0]          next_pe_src;
  logic                next_scan_dir;
  logic [EVT_W-1:0]    next_evt_stat;
  logic [EVT_W-1:0]    next_evt_mask;
  logic                next_xfer_irq;
  logic                next_irq;
  logic                wr_go;
  logic                pe_err;
  logic [EVT_W-1:0]    evt_set;

  // write strobe for a given offset, taken as waitrequest is low
  function automatic logic wr_hit(input logic [4:0] ofs);
    wr_hit = wr_go && (avs_address_i == ofs);
  endfunction

  // read mux; reserved and unmapped bits read zero
  function automatic logic [31:0] rd_mux(input logic [4:0] a);
    case (a)
      fsq_pkg::OFS_IRQ_EN:    rd_mux = {30'h0, irq_en};
      fsq_pkg::OFS_CMD_HIST:  rd_mux = {16'h0, cmd_hist};
      fsq_pkg::OFS_PE_SRC:    rd_mux = {24'h0, pe_src};
      fsq_pkg::OFS_BC_DIR:    rd_mux = {31'h0, scan_dir};
      fsq_pkg::OFS_XFER_STAT: rd_mux = {30'h0, xfer_stat};
      fsq_pkg::OFS_EVT_STAT:  rd_mux = {28'h0, evt_stat};
      fsq_pkg::OFS_EVT_MASK:  rd_mux = {28'h0, evt_mask};
      default:                rd_mux = 32'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // bus slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  assign wr_go = avs_write_i && !avs_waitrequest_o;

  // waitrequest drops for one cycle after a request is seen
  always_comb
  begin
    next_waitreq = !((avs_read_i || avs_write_i) && avs_waitrequest_o);
    next_rdata   = avs_readdata_o;
    if (avs_read_i && avs_waitrequest_o)
    begin
      next_rdata = rd_mux(avs_address_i);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
    end
    else
    begin
      avs_waitrequest_o <= next_waitreq;
      avs_readdata_o    <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // control and status registers
  // ----------------------------------------------------------------
  assign pe_err = pe_i.ready && (pe_i.erase_err || pe_i.prog_err);

  // next values for every software and hardware held field except evt_stat
  always_comb
  begin
    next_irq_en    = irq_en;
    next_xfer_stat = xfer_stat;
    next_cmd_hist  = cmd_hist;
    next_pe_src    = pe_src;
    next_scan_dir  = scan_dir;
    next_evt_mask  = evt_mask;
    // transfer error flags are sticky until reset
    next_xfer_stat[fsq_pkg::BIT_DOUBLE] = xfer_stat[fsq_pkg::BIT_DOUBLE] | double_err_i;
    next_xfer_stat[fsq_pkg::BIT_SINGLE] = xfer_stat[fsq_pkg::BIT_SINGLE]
                                          | single_corr_i;
    if (wr_hit(fsq_pkg::OFS_IRQ_EN))
    begin
      next_irq_en = avs_writedata_i[1:0];
    end
    if (wr_hit(fsq_pkg::OFS_EVT_MASK))
    begin
      next_evt_mask = avs_writedata_i[EVT_W-1:0];
    end
    // command history
    if (cmd_accept_i)
    begin
      if (cmd_i.two_step)
      begin
        next_cmd_hist = {cmd_i.code, cmd_i.prefix};
      end
      else
      begin
        next_cmd_hist = {cmd_i.code, cmd_hist[15:8]};
      end
    end
    // error source is captured only while it is valid, else held
    if (pe_err)
    begin
      next_pe_src = pe_i.source;
    end
    // direction bit; setup init clears it and wins over a write
    if (wr_hit(fsq_pkg::OFS_BC_DIR))
    begin
      next_scan_dir = avs_writedata_i[fsq_pkg::BIT_SCAN];
    end
    if (wr_hit(fsq_pkg::OFS_SETUP) && avs_writedata_i[fsq_pkg::BIT_SETUP])
    begin
      next_scan_dir = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_en           <= fsq_pkg::IRQ_EN_RST;
      xfer_stat        <= 2'h0;
      cmd_hist         <= fsq_pkg::CMD_RST;
      pe_src           <= fsq_pkg::PE_SRC_RST;
      scan_dir         <= 1'b0;
      evt_mask         <= '0;
      scan_direction_o <= 1'b0;
    end
    else
    begin
      irq_en           <= next_irq_en;
      xfer_stat        <= next_xfer_stat;
      cmd_hist         <= next_cmd_hist;
      pe_src           <= next_pe_src;
      scan_dir         <= next_scan_dir;
      evt_mask         <= next_evt_mask;
      scan_direction_o <= next_scan_dir;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign evt_set = {pe_err, cmd_accept_i, single_corr_i, double_err_i};

  // sticky events; a set in the clearing cycle wins
  always_comb
  begin
    next_evt_stat = evt_stat;
    if (wr_hit(fsq_pkg::OFS_EVT_STAT))
    begin
      next_evt_stat = evt_stat & ~avs_writedata_i[EVT_W-1:0];
    end
    next_evt_stat = next_evt_stat | evt_set;
    next_irq      = |(next_evt_stat & next_evt_mask);
    // the request is a level: any sticky flag with its enable set
    next_xfer_irq = (next_xfer_stat[fsq_pkg::BIT_DOUBLE]
                     && next_irq_en[fsq_pkg::BIT_DOUBLE])
                    || (next_xfer_stat[fsq_pkg::BIT_SINGLE]
                        && next_irq_en[fsq_pkg::BIT_SINGLE]);
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_stat             <= '0;
      irq_o                <= 1'b0;
      transfer_error_irq_o <= 1'b0;
    end
    else
    begin
      evt_stat             <= next_evt_stat;
      irq_o                <= next_irq;
      transfer_error_irq_o <= next_xfer_irq;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  // flag, request, history, source, direction, bus and event checks
  chk_double_flag_set: assert property (double_err_i |=> xfer_stat[1])
    else $error("double detect flag not set");
  chk_single_flag_set: assert property (single_corr_i |=> xfer_stat[0])
    else $error("single correct flag not set");
  chk_double_irq: assert property (
    (xfer_stat[1] && irq_en[1]) |-> transfer_error_irq_o)
    else $error("double error request missing");
  chk_single_irq: assert property (
    (xfer_stat[0] && irq_en[0]) |-> transfer_error_irq_o)
    else $error("single error request missing");
  chk_xfer_quiet: assert property (
    !(xfer_stat[1] && irq_en[1]) && !(xfer_stat[0] && irq_en[0])
    |-> !transfer_error_irq_o)
    else $error("transfer error request without an enabled flag");
  chk_no_irq_masked: assert property (
    (irq_en == 2'h0) ##1 (irq_en == 2'h0) |-> !transfer_error_irq_o)
    else $error("transfer error request while disabled");
  chk_reserved_zero: assert property (
    (!avs_waitrequest_o && $past(avs_address_i) == fsq_pkg::OFS_BC_DIR && $past(avs_read_i))
    |-> avs_readdata_o[31:1] == 31'h0)
    else $error("reserved bits read nonzero");
  chk_cmd_single: assert property (
    (cmd_accept_i && !cmd_i.two_step)
    |=> cmd_hist == {$past(cmd_i.code), $past(cmd_hist[15:8])})
    else $error("single step history wrong");
  chk_cmd_two_step: assert property (
    (cmd_accept_i && cmd_i.two_step)
    |=> cmd_hist == {$past(cmd_i.code), $past(cmd_i.prefix)})
    else $error("two step history wrong");
  chk_cmd_hold: assert property (!cmd_accept_i |=> $stable(cmd_hist))
    else $error("command history changed without a command");
  chk_pe_hold: assert property (!pe_err |=> $stable(pe_src))
    else $error("error source changed without error");
  chk_pe_capture: assert property (pe_err |=> pe_src == $past(pe_i.source))
    else $error("error source not captured");
  chk_setup_clears: assert property (
    (wr_hit(fsq_pkg::OFS_SETUP) && avs_writedata_i[0]) |=> !scan_direction_o)
    else $error("direction not cleared by setup init");
  chk_scan_write: assert property (
    wr_hit(fsq_pkg::OFS_BC_DIR)
    |=> scan_direction_o == $past(avs_writedata_i[fsq_pkg::BIT_SCAN]))
    else $error("direction write not applied");
  chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer timing wrong");
  chk_evt_set_wins: assert property ((evt_set != '0)
    |=> (evt_stat & $past(evt_set)) == $past(evt_set))
    else $error("event lost against a clear");
  chk_irq_level: assert property (irq_o == |(evt_stat & evt_mask))
    else $error("interrupt level does not follow status and mask");

endmodule
`default_nettype wire

/* File: testbench.sv */
/*
  testbench: self-checking bench for fsq_regs, compared with a small
  model held in the bench.
  assumes: fsq_pkg and fsq_regs compiled first; the bench is the bus master.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic              clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic [4:0]        adr = 5'h00;
  logic              rd = 1'b0;
  logic              wr = 1'b0;
  logic [31:0]       wdat = 32'h0;
  logic [31:0]       rdat;
  logic              wt;
  logic              dbl = 1'b0;
  logic              sgl = 1'b0;
  logic              acc = 1'b0;
  fsq_pkg::fsq_cmd_t cmd = '0;
  fsq_pkg::fsq_pe_t  pe = '0;
  logic              tei;
  logic              dir;
  logic              irq;
  integer            bad_count = 0;
  integer            total_checks = 0;
  integer            seed = 82595;
  integer            i;
  integer            k;
  logic [15:0]       m_hist;
  logic [31:0]       got;
  logic [7:0]        codes [0:10] = '{8'he8, 8'hea, 8'hb0, 8'hd0, 8'h50, 8'hb3, 8'h40,
                                      8'h45, 8'h20, 8'h71, 8'h77};
  logic [7:0]        srcs [0:3] = '{8'h01, 8'h02, 8'h12, 8'h00};

  // 250 mhz clock
  always #2 clk_i = ~clk_i;

  fsq_regs u_fsq_regs
  (
    .clk_i                (clk_i),
    .nrst_i               (nrst_i),
    .avs_address_i        (adr),
    .avs_read_i           (rd),
    .avs_write_i          (wr),
    .avs_writedata_i      (wdat),
    .avs_readdata_o       (rdat),
    .avs_waitrequest_o    (wt),
    .double_err_i         (dbl),
    .single_corr_i        (sgl),
    .cmd_accept_i         (acc),
    .cmd_i                (cmd),
    .pe_i                 (pe),
    .transfer_error_irq_o (tei),
    .scan_direction_o     (dir),
    .irq_o                (irq)
  );

  // -------------------------------------------------------------
  // helper tasks
  // -------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge clk_i);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wdat <= d;
    @(posedge clk_i);
    while (wt !== 1'b0 && n < 50)
    begin
      @(posedge clk_i);
      n = n + 1;
    end
    if (n >= 50)
    begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t: bus answer timed out", $time);
    end
    got = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_i);
  endtask

  task automatic pulse(input logic d, input logic s);
    @(posedge clk_i);
    dbl <= d;
    sgl <= s;
    @(posedge clk_i);
    dbl <= 1'b0;
    sgl <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    m_hist = 16'h0000;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial
  begin
    do_reset();
    for (k = 0; k < 8; k++)
    begin
      bus(1'b0, 5'(k * 4), 32'h0);
      check(got, 32'h0);
    end
    bus(1'b1, fsq_pkg::OFS_IRQ_EN, 32'h3);
    bus(1'b0, fsq_pkg::OFS_IRQ_EN, 32'h0);
    check(got, 32'h3);
    bus(1'b1, fsq_pkg::OFS_IRQ_EN, 32'h0);
    bus(1'b1, fsq_pkg::OFS_CMD_HIST, 32'hffff);
    bus(1'b0, fsq_pkg::OFS_CMD_HIST, 32'h0);
    check(got, 32'h0);
    bus(1'b1, fsq_pkg::OFS_BC_DIR, 32'h1);
    bus(1'b0, fsq_pkg::OFS_BC_DIR, 32'h0);
    check(got, 32'h1);
    settle();
    check(32'(dir), 32'h1);
    bus(1'b1, fsq_pkg::OFS_SETUP, 32'h1);
    settle();
    check(32'(dir), 32'h0);
    bus(1'b1, fsq_pkg::OFS_BC_DIR, 32'h1);
    do_reset();
    check(32'(dir), 32'h0);
    $display("test registers done");
    // transfer errors against each enable
    pulse(1'b1, 1'b0);
    settle();
    check(32'(tei), 32'h0);
    bus(1'b0, fsq_pkg::OFS_XFER_STAT, 32'h0);
    check(got, 32'h2);
    bus(1'b1, fsq_pkg::OFS_IRQ_EN, 32'h1);
    settle();
    check(32'(tei), 32'h0);
    bus(1'b1, fsq_pkg::OFS_IRQ_EN, 32'h2);
    settle();
    check(32'(tei), 32'h1);
    bus(1'b1, fsq_pkg::OFS_IRQ_EN, 32'h0);
    pulse(1'b0, 1'b1);
    settle();
    check(32'(tei), 32'h0);
    bus(1'b0, fsq_pkg::OFS_XFER_STAT, 32'h0);
    check(got, 32'h3);
    bus(1'b1, fsq_pkg::OFS_IRQ_EN, 32'h1);
    settle();
    check(32'(tei), 32'h1);
    $display("test transfer errors done");
    // every command code once, then random ones
    for (i = 0; i < 22; i++)
    begin
      k = (i < 11) ? i : (($random(seed) & 32'h7fffffff) % 11);
      @(posedge clk_i);
      acc <= 1'b1;
      if (k >= 8)
        cmd <= '{1'b1, codes[k], 8'hd0};
      else
        cmd <= '{1'b0, 8'($random(seed)), codes[k]};
      @(posedge clk_i);
      acc <= 1'b0;
      m_hist = (k >= 8) ? {8'hd0, codes[k]} : {codes[k], m_hist[15:8]};
      bus(1'b0, fsq_pkg::OFS_CMD_HIST, 32'h0);
      check(got, 32'(m_hist));
    end
    $display("test commands done");
    // error source capture and hold
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      pe <= '{1'b1, i[0], ~i[0], srcs[i]};
      @(posedge clk_i);
      pe <= '{1'b1, 1'b0, 1'b0, 8'($random(seed))};
      bus(1'b0, fsq_pkg::OFS_PE_SRC, 32'h0);
      check(got, 32'(srcs[i]));
      pe <= '{1'b0, 1'b1, 1'b1, 8'($random(seed))};
      bus(1'b0, fsq_pkg::OFS_PE_SRC, 32'h0);
      check(got, 32'(srcs[i]));
    end
    $display("test error source done");
    // sticky events, mask and write-one-to-clear
    bus(1'b0, fsq_pkg::OFS_EVT_STAT, 32'h0);
    check(got, 32'hf);
    settle();
    check(32'(irq), 32'h0);
    bus(1'b1, fsq_pkg::OFS_EVT_MASK, 32'h4);
    settle();
    check(32'(irq), 32'h1);
    bus(1'b1, fsq_pkg::OFS_EVT_STAT, 32'hb);
    bus(1'b0, fsq_pkg::OFS_EVT_STAT, 32'h0);
    check(got, 32'h4);
    bus(1'b1, fsq_pkg::OFS_EVT_STAT, 32'h4);
    settle();
    check(32'(irq), 32'h0);
    do_reset();
    check(32'(tei), 32'h0);
    bus(1'b0, fsq_pkg::OFS_XFER_STAT, 32'h0);
    check(got, 32'h0);
    $display("test events done");
    stop_test();
  end

  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count = bad_count + 1;
    $display("[FAIL] %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
`default_nettype wire
